// File: shared/flash_consts.svh
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH
// system clock and programming clock
`define CLK_PERIOD_NS 20
`define PROG_CLK_NS 320
`define HALF_CYCLES ((`PROG_CLK_NS / `CLK_PERIOD_NS) / 2)
// link framing
`define CODE_BITS 4
`define WORD_BITS 16
`define IDLE_CLOCKS 8
`define READ_CLOCKS 16
`define WRITE_FRAME (`CODE_BITS + `WORD_BITS)
`define READ_FIRST (`CODE_BITS + `IDLE_CLOCKS)
`define READ_END (`READ_FIRST + `READ_CLOCKS)
`define READ_FRAME (`READ_END + 1)
`define CODE_READOUT 4'h1
`define CODE_WRITE_CTRL 4'h2
`define CODE_WRITE_PAGE 4'h3
// operation control fields
`define START_BIT 15
`define OP_CHIP_ERASE 15'h404F
`define OP_PAGE_ERASE 15'h4042
`define OP_CONFIG_WRITE 15'h4003
`define OP_ROW_WRITE 15'h4001
`define CONFIG_PAGE_BASE 8'h80
`define ROW_WORDS 7'h40
`define ONE_WORD 7'h01
`define CTRL_RESET 16'h0000
`define PAGE_RESET 8'h00
// self-timed operation durations
`define ERASE_TIME_US 5000
`define WRITE_TIME_US 2000
`define ERASE_CYCLES ((`ERASE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYCLES ((`WRITE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// host register map
`define REG_CMD 8'h00
`define REG_TXDATA 8'h04
`define REG_RXDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h14
`define CMD_READOUT 2'h0
`define CMD_WRITE_CTRL 2'h1
`define CMD_WRITE_PAGE 2'h2
`define IRQ_FRAME_BIT 0
`define IRQ_READ_BIT 1
`endif

// File: shared/flash_pkg.sv
`default_nettype none
package flash_pkg;
	typedef enum logic [2:0] {
		D_CODE = 3'h0,
		D_DATA = 3'h1,
		D_IDLE = 3'h2,
		D_SHIFT = 3'h3,
		D_HOLD = 3'h4
	} dev_state_t;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_LOW = 2'h1,
		H_HIGH = 2'h2
	} host_state_t;
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_CHIP_ERASE = 3'h1,
		OP_PAGE_ERASE = 3'h2,
		OP_CONFIG_WRITE = 3'h3,
		OP_ROW_WRITE = 3'h4
	} op_kind_t;
endpackage
`default_nettype wire

// File: shared/prog_link_if.sv
`default_nettype none
interface prog_link_if;
	logic clk_pin;
	logic host_dout;
	logic host_oe;
	logic dev_dout;
	logic dev_oe;
	logic data_level;
	// resolved data pin, pulled high when nobody drives
	assign data_level = dev_oe ? dev_dout : (host_oe ? host_dout : 1'b1);
	modport host (output clk_pin, output host_dout, output host_oe,
		input data_level);
	modport dev (input clk_pin, input data_level, output dev_dout,
		output dev_oe);
endinterface
`default_nettype wire

// File: verification/serial_flash_program_port_props.sv
`default_nettype none
module serial_flash_program_port_props (
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// programming link
	input wire logic clk_pin,
	input wire logic host_dout,
	input wire logic host_oe,
	input wire logic dev_dout,
	input wire logic dev_oe,
	input wire logic data_level
);
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_q;
	logic rise;
	logic [5:0] hrise_q;
	logic [5:0] drise_q;
	logic [4:0] idle_q;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// link clock rise seen in the system clock
	assign rise = clk_pin & ~clk_q;
	// rises per driver and rises while nobody drives
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clk_q <= 1'b0;
			hrise_q <= 6'h00;
			drise_q <= 6'h00;
			idle_q <= 5'h00;
		end
		else
		begin
			clk_q <= clk_pin;
			hrise_q <= host_oe ? hrise_q + 6'(rise) : 6'h00;
			drise_q <= dev_oe ? drise_q + 6'(rise) : 6'h00;
			idle_q <= (host_oe | dev_oe) ? 5'h00 : idle_q + 5'(rise);
		end
	end
	a_oe_exclusive: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the data pin");
	a_host_on_fall: assert property (($changed(host_dout) ||
		$changed(host_oe)) |-> !clk_pin)
		else $error("host data changed while clock high");
	a_dev_on_fall: assert property ((dev_oe && $past(dev_oe) &&
		$changed(dev_dout)) |-> !clk_pin && !$past(clk_pin, 2))
		else $error("device data changed off the falling edge");
	a_dev_drive_low: assert property ($rose(dev_oe) |-> !clk_pin)
		else $error("device took the pin while clock high");
	a_idle_eight: assert property ($rose(dev_oe) |-> idle_q == 5'h08)
		else $error("idle clocks before readout not eight");
	a_dev_release: assert property ($fell(dev_oe) |->
		clk_pin && drise_q == 6'h11)
		else $error("device released pin at wrong clock");
	a_host_frame_len: assert property ($fell(host_oe) |->
		hrise_q == 6'h04 || hrise_q == 6'h14)
		else $error("host drive length wrong");
	a_clk_half: assert property ($rose(clk_pin) |->
		clk_pin [*8] ##1 !clk_pin)
		else $error("link clock high phase wrong");
endmodule
`default_nettype wire

// File: verification/serial_flash_program_port_tb_top.sv
`default_nettype none
`include "flash_consts.svh"
module serial_flash_program_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EC = 1500;
	localparam int WC = 700;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, cprev;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic cpu_idle, op_start, op_erase_config, op_busy;
	logic [7:0] op_page;
	logic [6:0] op_words;
	flash_pkg::op_kind_t op_kind;
	int fails, n_compared, icnt, bcnt;
	logic [7:0] page;
	logic [15:0] v;
	logic wq[$];
	logic [31:0] eq[$];
	int bq[$];
	prog_link_if link ();
	prog_port_host i_prog_port_host (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .irq(irq), .link(link));
	prog_port_device #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC))
		i_prog_port_device (.hclk(hclk), .hresetn(hresetn), .link(link),
		.cpu_idle(cpu_idle), .op_start(op_start), .op_kind(op_kind),
		.op_page(op_page), .op_erase_config(op_erase_config),
		.op_words(op_words), .op_busy(op_busy));
	serial_flash_program_port_props i_props (.hclk(hclk), .hresetn(hresetn),
		.clk_pin(link.clk_pin), .host_dout(link.host_dout),
		.host_oe(link.host_oe), .dev_dout(link.dev_dout),
		.dev_oe(link.dev_oe), .data_level(link.data_level));
	// ***********************************
	// clock, monitors, helpers
	// ***********************************
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// link bits at clock rise, idle span, started operations, busy span
	always @(posedge hclk)
	begin
		cprev <= link.clk_pin;
		if (link.clk_pin === 1'b1 && cprev === 1'b0)
			wq.push_back(link.data_level);
		icnt <= (cpu_idle === 1'b1) ? icnt + 1 : 0;
		if (cpu_idle !== 1'b1 && icnt > 0)
			chk(32'(icnt >= 120 && icnt <= 136), 32'h00000001);
		bcnt <= (op_busy === 1'b1) ? bcnt + 1 : 0;
		if (op_busy !== 1'b1 && bcnt > 0)
			chk(bcnt, bq.pop_front());
		if (op_start === 1'b1)
			chk({13'h0000, op_kind, op_words, op_page, op_erase_config},
				eq.pop_front());
	end
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h00000000, hresp}, 32'h00000000);
	endtask
	task automatic frame(input logic [1:0] cmd);
		int n;
		wq.delete();
		ahb(1'b1, `REG_CMD, {30'h00000000, cmd});
		n = 0;
		do
		begin
			ahb(1'b0, `REG_STATUS, 32'h00000000);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 600);
		// a frame that never ends counts as a mismatch
		if (rd[0] !== 1'b0)
			chk(rd, 32'h00000000);
	endtask
	task automatic wire_chk(input logic [3:0] code, input logic [15:0] val,
		input int first, input int total);
		logic [3:0] c;
		logic [15:0] d;
		for (int i = 0; i < 4; i++)
			c[i] = wq[i];
		for (int i = 0; i < 16; i++)
			d[i] = wq[first + i];
		chk({12'h000, c, d}, {12'h000, code, val});
		chk(wq.size(), total);
	endtask
	task automatic readout(input logic [15:0] exp);
		frame(`CMD_READOUT);
		wire_chk(`CODE_READOUT, exp, 12, 29);
		ahb(1'b0, `REG_RXDATA, 32'h00000000);
		chk(rd, {16'h0000, exp});
	endtask
	task automatic wctl(input logic [15:0] d, input logic [1:0] cmd);
		ahb(1'b1, `REG_TXDATA, {16'h0000, d});
		frame(cmd);
		wire_chk(cmd == `CMD_WRITE_PAGE ? `CODE_WRITE_PAGE : `CODE_WRITE_CTRL,
			d, 4, 20);
	endtask
	task automatic op_run(input logic [14:0] code,
		input flash_pkg::op_kind_t k, input logic [6:0] w, input int cyc);
		int n;
		eq.push_back({13'h0000, k, w, page,
			(k == flash_pkg::OP_CHIP_ERASE) & page[7]});
		bq.push_back(cyc);
		wctl({1'b1, code}, `CMD_WRITE_CTRL);
		if (cyc == EC)
			wctl(16'h1234, `CMD_WRITE_CTRL);
		readout({1'b1, code});
		n = 0;
		do
		begin
			frame(`CMD_READOUT);
			ahb(1'b0, `REG_RXDATA, 32'h00000000);
			n++;
		end
		while (rd[15] !== 1'b0 && n < 10);
		if (rd[15] !== 1'b0)
			chk(rd, {17'h00000, code});
		readout({1'b0, code});
		$display("done: operation %h", code);
	endtask
	task automatic conclude();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ***********************************
	// test sequence
	// ***********************************
	initial
	begin
		{hresetn, hsel, hwrite, cprev, icnt, bcnt} = '0;
		{haddr, hwdata, htrans, page} = '0;
		void'($urandom(32'hA8B80829));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// every register and one unmapped word read zero after reset
		for (int i = 0; i < 7; i++)
		begin
			ahb(1'b0, 8'(i * 4), 32'h00000000);
			chk(rd, 32'h00000000);
		end
		readout(16'h0000);
		$display("done: reset values");
		// command code 3 starts no frame
		ahb(1'b1, `REG_CMD, 32'h00000003);
		ahb(1'b0, `REG_STATUS, 32'h00000000);
		chk(rd, 32'h00000000);
		ahb(1'b0, `REG_IRQ_STATUS, 32'h00000000);
		chk(rd, 32'h00000003);
		chk({31'h00000000, irq}, 32'h00000000);
		ahb(1'b1, `REG_IRQ_MASK, 32'h00000002);
		ahb(1'b0, `REG_IRQ_STATUS, 32'h00000000);
		chk(rd, 32'h00000003);
		chk({31'h00000000, irq}, 32'h00000001);
		ahb(1'b1, `REG_IRQ_STATUS, 32'h00000002);
		ahb(1'b0, `REG_IRQ_STATUS, 32'h00000000);
		chk(rd, 32'h00000001);
		chk({31'h00000000, irq}, 32'h00000000);
		ahb(1'b1, `REG_IRQ_MASK, 32'h00000003);
		ahb(1'b0, `REG_IRQ_STATUS, 32'h00000000);
		chk({31'h00000000, irq}, 32'h00000001);
		ahb(1'b1, `REG_IRQ_STATUS, 32'h00000003);
		ahb(1'b0, `REG_IRQ_STATUS, 32'h00000000);
		chk(rd, 32'h00000000);
		chk({31'h00000000, irq}, 32'h00000000);
		$display("done: interrupts");
		repeat (4)
		begin
			v = 16'($urandom & 32'h00007FFF);
			wctl(v, `CMD_WRITE_CTRL);
			readout(v);
		end
		wctl(16'hC000, `CMD_WRITE_CTRL);
		readout(16'h4000);
		$display("done: control values");
		for (int i = 0; i < 2; i++)
		begin
			page = i ? 8'h80 : 8'h7F;
			wctl({8'h00, page}, `CMD_WRITE_PAGE);
			op_run(15'h404F, flash_pkg::OP_CHIP_ERASE, 7'h00, EC);
		end
		op_run(15'h4042, flash_pkg::OP_PAGE_ERASE, 7'h00, EC);
		op_run(15'h4003, flash_pkg::OP_CONFIG_WRITE, 7'h01, WC);
		op_run(15'h4001, flash_pkg::OP_ROW_WRITE, 7'h40, WC);
		// every expected start and busy span was seen
		chk(32'(eq.size() + bq.size()), 32'h00000000);
		conclude();
	end
	// cut a hung run short
	initial
	begin
		#1500000;
		fails++;
		conclude();
	end
endmodule
`default_nettype wire

// File: verilog/prog_port_device.sv
// Implementation choices: the register offsets and register access over AHB-Lite.
`default_nettype none
`include "flash_consts.svh"
// Notes on behaviour
// - processor idle eight clocks after readout code
// - sixteen more clocks shift visible register out
// - data pin is input during readout code
// - after code, device drives visible bits out
// - keep driving until next clock rising edge
// - change data on falling, sample on rising
// - every transfer least significant bit first
// - control value selects operation, bit 15 starts
// - operations self-timed, start bit cleared when done
// - 404Fh erases code, executive and configuration
// - 4042h erases one page
// - 4003h programs one configuration word
// - 4001h programs one row of 64 words
// - programmer polls start bit for completion
// - page below 80h spares configuration on chip erase
module prog_port_device #(
	parameter int ERASE_CYCLES = `ERASE_CYCLES,
	parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// programming link
	prog_link_if.dev link,
	// flash macro side
	output logic cpu_idle,
	output logic op_start,
	output var flash_pkg::op_kind_t op_kind,
	output logic [7:0] op_page,
	output logic op_erase_config,
	output logic [6:0] op_words,
	output logic op_busy
);

	// ****************************************
	// operation decode
	// ****************************************

	function automatic flash_pkg::op_kind_t op_decode(input logic [14:0] v);
		flash_pkg::op_kind_t k;
		k = flash_pkg::OP_NONE;
		if (v == `OP_CHIP_ERASE)
			k = flash_pkg::OP_CHIP_ERASE;
		else if (v == `OP_PAGE_ERASE)
			k = flash_pkg::OP_PAGE_ERASE;
		else if (v == `OP_CONFIG_WRITE)
			k = flash_pkg::OP_CONFIG_WRITE;
		else if (v == `OP_ROW_WRITE)
			k = flash_pkg::OP_ROW_WRITE;
		return k;
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************

	logic [1:0] clk_s_q, clk_s_d;
	logic [1:0] dat_s_q, dat_s_d;
	logic clk_p_q, clk_p_d;
	logic rise, fall, din;

	// two flops per pin, then edge detect on the second
	always_comb
	begin
		clk_s_d = {clk_s_q[0], link.clk_pin};
		dat_s_d = {dat_s_q[0], link.data_level};
		clk_p_d = clk_s_q[1];
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			clk_s_q <= 2'h0;
			dat_s_q <= 2'h3;
			clk_p_q <= 1'b0;
		end
		else
		begin
			clk_s_q <= clk_s_d;
			dat_s_q <= dat_s_d;
			clk_p_q <= clk_p_d;
		end
	end

	assign rise = clk_s_q[1] & ~clk_p_q;
	assign fall = ~clk_s_q[1] & clk_p_q;
	assign din = dat_s_q[1];

	// ****************************************
	// link frame machine
	// ****************************************

	flash_pkg::dev_state_t st_q, st_d;
	logic [4:0] cnt_q, cnt_d;
	logic [3:0] code_q, code_d;
	logic [15:0] visible_shift_q, visible_shift_d;
	logic oe_q, oe_d;
	logic dout_q, dout_d;
	logic idle_q, idle_d;
	logic [15:0] nonvolatile_operation_control_q;
	logic [15:0] nonvolatile_operation_control_d;
	logic wr_ctrl, wr_page;
	logic [15:0] wdata;
	logic [3:0] code_in;

	// code, payload, idle, shift out and release
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		code_d = code_q;
		visible_shift_d = visible_shift_q;
		oe_d = oe_q;
		dout_d = dout_q;
		idle_d = idle_q;
		wr_ctrl = 1'b0;
		wr_page = 1'b0;
		wdata = {din, visible_shift_q[15:1]};
		code_in = {din, code_q[3:1]};
		case (st_q)
			flash_pkg::D_CODE:
				if (rise)
				begin
					code_d = code_in;
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == 5'(`CODE_BITS - 1))
					begin
						cnt_d = 5'h00;
						if (code_in == `CODE_READOUT)
						begin
							st_d = flash_pkg::D_IDLE;
							idle_d = 1'b1;
						end
						else if (code_in == `CODE_WRITE_CTRL ||
							code_in == `CODE_WRITE_PAGE)
							st_d = flash_pkg::D_DATA;
					end
				end
			flash_pkg::D_DATA:
				if (rise)
				begin
					visible_shift_d = wdata;
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == 5'(`WORD_BITS - 1))
					begin
						cnt_d = 5'h00;
						st_d = flash_pkg::D_CODE;
						wr_ctrl = (code_q == `CODE_WRITE_CTRL);
						wr_page = (code_q == `CODE_WRITE_PAGE);
					end
				end
			flash_pkg::D_IDLE:
				if (rise)
				begin
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == 5'(`IDLE_CLOCKS - 1))
					begin
						cnt_d = 5'h00;
						idle_d = 1'b0;
						st_d = flash_pkg::D_SHIFT;
						visible_shift_d = nonvolatile_operation_control_q;
					end
				end
			flash_pkg::D_SHIFT:
				if (fall)
				begin
					oe_d = 1'b1;
					dout_d = visible_shift_q[0];
					visible_shift_d = {1'b0, visible_shift_q[15:1]};
					cnt_d = cnt_q + 5'h01;
				end
				else if (rise && cnt_q == 5'(`READ_CLOCKS))
				begin
					cnt_d = 5'h00;
					st_d = flash_pkg::D_HOLD;
				end
			flash_pkg::D_HOLD:
				if (rise)
				begin
					oe_d = 1'b0;
					st_d = flash_pkg::D_CODE;
				end
			default:
				st_d = flash_pkg::D_CODE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_q <= flash_pkg::D_CODE;
			cnt_q <= 5'h00;
			code_q <= 4'h0;
			visible_shift_q <= 16'h0000;
			oe_q <= 1'b0;
			dout_q <= 1'b0;
			idle_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			code_q <= code_d;
			visible_shift_q <= visible_shift_d;
			oe_q <= oe_d;
			dout_q <= dout_d;
			idle_q <= idle_d;
		end
	end

	// ****************************************
	// operation control and timer
	// ****************************************

	logic [7:0] table_page_q, table_page_d;
	logic [31:0] timer_q, timer_d;
	logic start_q, start_d;
	flash_pkg::op_kind_t kind_q, kind_d, kind_new;
	logic cfg_q, cfg_d;
	logic [6:0] words_q, words_d;
	logic busy_q, busy_d;

	// writes while busy are dropped so the running op is not disturbed
	always_comb
	begin
		nonvolatile_operation_control_d = nonvolatile_operation_control_q;
		table_page_d = table_page_q;
		timer_d = timer_q;
		start_d = 1'b0;
		kind_d = kind_q;
		cfg_d = cfg_q;
		words_d = words_q;
		busy_d = busy_q;
		kind_new = op_decode(wdata[14:0]);
		if (busy_q)
		begin
			if (timer_q == 32'h0000_0000)
			begin
				busy_d = 1'b0;
				nonvolatile_operation_control_d[`START_BIT] = 1'b0;
			end
			else
				timer_d = timer_q - 32'h0000_0001;
		end
		else if (wr_page)
			table_page_d = wdata[7:0];
		else if (wr_ctrl)
		begin
			nonvolatile_operation_control_d = wdata;
			if (wdata[`START_BIT])
			begin
				if (kind_new == flash_pkg::OP_NONE)
					nonvolatile_operation_control_d[`START_BIT] = 1'b0;
				else
				begin
					start_d = 1'b1;
					busy_d = 1'b1;
					kind_d = kind_new;
					cfg_d = (kind_new == flash_pkg::OP_CHIP_ERASE) &&
						(table_page_q >= `CONFIG_PAGE_BASE);
					if (kind_new == flash_pkg::OP_ROW_WRITE)
						words_d = `ROW_WORDS;
					else if (kind_new == flash_pkg::OP_CONFIG_WRITE)
						words_d = `ONE_WORD;
					else
						words_d = 7'h00;
					if (kind_new == flash_pkg::OP_CHIP_ERASE ||
						kind_new == flash_pkg::OP_PAGE_ERASE)
						timer_d = 32'(ERASE_CYCLES - 1);
					else
						timer_d = 32'(WRITE_CYCLES - 1);
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			nonvolatile_operation_control_q <= `CTRL_RESET;
			table_page_q <= `PAGE_RESET;
			timer_q <= 32'h0000_0000;
			start_q <= 1'b0;
			kind_q <= flash_pkg::OP_NONE;
			cfg_q <= 1'b0;
			words_q <= 7'h00;
			busy_q <= 1'b0;
		end
		else
		begin
			nonvolatile_operation_control_q <= nonvolatile_operation_control_d;
			table_page_q <= table_page_d;
			timer_q <= timer_d;
			start_q <= start_d;
			kind_q <= kind_d;
			cfg_q <= cfg_d;
			words_q <= words_d;
			busy_q <= busy_d;
		end
	end

	// outputs, all from flops
	assign link.dev_dout = dout_q;
	assign link.dev_oe = oe_q;
	assign cpu_idle = idle_q;
	assign op_start = start_q;
	assign op_kind = kind_q;
	assign op_page = table_page_q;
	assign op_erase_config = cfg_q;
	assign op_words = words_q;
	assign op_busy = busy_q;

endmodule
`default_nettype wire

// File: verilog/prog_port_host.sv
`default_nettype none
`include "flash_consts.svh"
module prog_port_host (
	// system
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq,
	// programming link
	prog_link_if.host link
);

	// ****************************************
	// register slave
	// ****************************************

	flash_pkg::host_state_t hst_q, hst_d;
	logic wpend_q, wpend_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] hrdata_q, hrdata_d;
	logic [15:0] tx_q, tx_d;
	logic [15:0] rx_q, rx_d;
	logic [1:0] sel_q, sel_d;
	logic [1:0] ist_q, ist_d, mask_q, mask_d;
	logic irq_q, irq_d;
	logic go, done_ev;
	logic rd_q, rd_d;

	// address phase latches, data phase writes; zero wait states
	always_comb
	begin
		wpend_d = 1'b0;
		waddr_d = waddr_q;
		hrdata_d = hrdata_q;
		tx_d = tx_q;
		sel_d = sel_q;
		mask_d = mask_q;
		ist_d = ist_q;
		go = 1'b0;
		if (hsel && hready && htrans[1])
		begin
			wpend_d = hwrite;
			waddr_d = haddr[7:0];
			hrdata_d = 32'h0000_0000;
			if (haddr[7:0] == `REG_TXDATA)
				hrdata_d = {16'h0000, tx_q};
			else if (haddr[7:0] == `REG_RXDATA)
				hrdata_d = {16'h0000, rx_q};
			else if (haddr[7:0] == `REG_STATUS)
				hrdata_d = {31'h0000_0000, hst_q != flash_pkg::H_IDLE};
			else if (haddr[7:0] == `REG_IRQ_STATUS)
				hrdata_d = {30'h0000_0000, ist_q};
			else if (haddr[7:0] == `REG_IRQ_MASK)
				hrdata_d = {30'h0000_0000, mask_q};
		end
		if (wpend_q)
		begin
			if (waddr_q == `REG_CMD)
			begin
				go = (hst_q == flash_pkg::H_IDLE) && (hwdata[1:0] != 2'h3);
				if (go)
					sel_d = hwdata[1:0];
			end
			else if (waddr_q == `REG_TXDATA)
				tx_d = hwdata[15:0];
			else if (waddr_q == `REG_IRQ_STATUS)
				ist_d = ist_q & ~hwdata[1:0];
			else if (waddr_q == `REG_IRQ_MASK)
				mask_d = hwdata[1:0];
		end
		// a new event wins over a clear in the same cycle
		ist_d[`IRQ_FRAME_BIT] = ist_d[`IRQ_FRAME_BIT] | done_ev;
		ist_d[`IRQ_READ_BIT] = ist_d[`IRQ_READ_BIT] | (done_ev & rd_q);
		irq_d = |(ist_d & mask_d);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wpend_q <= 1'b0;
			waddr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
			tx_q <= 16'h0000;
			sel_q <= `CMD_READOUT;
			mask_q <= 2'h0;
			ist_q <= 2'h0;
			irq_q <= 1'b0;
		end
		else
		begin
			wpend_q <= wpend_d;
			waddr_q <= waddr_d;
			hrdata_q <= hrdata_d;
			tx_q <= tx_d;
			sel_q <= sel_d;
			mask_q <= mask_d;
			ist_q <= ist_d;
			irq_q <= irq_d;
		end
	end

	// ****************************************
	// link frame generator
	// ****************************************

	logic [1:0] dat_s_q, dat_s_d;
	logic [3:0] div_q, div_d;
	logic [4:0] n_q, n_d;
	logic [19:0] hsh_q, hsh_d;
	logic clk_q, clk_d, oe_q, oe_d, dout_q, dout_d;
	logic [3:0] code;
	logic [4:0] total, drive;

	// clock made by dividing hclk; data set at fall, sampled at rise
	always_comb
	begin
		dat_s_d = {dat_s_q[0], link.data_level};
		hst_d = hst_q;
		div_d = div_q;
		n_d = n_q;
		hsh_d = hsh_q;
		clk_d = clk_q;
		oe_d = oe_q;
		dout_d = dout_q;
		rx_d = rx_q;
		rd_d = rd_q;
		done_ev = 1'b0;
		total = rd_q ? 5'(`READ_FRAME) : 5'(`WRITE_FRAME);
		drive = rd_q ? 5'(`CODE_BITS) : 5'(`WRITE_FRAME);
		if (sel_d == `CMD_WRITE_CTRL)
			code = `CODE_WRITE_CTRL;
		else if (sel_d == `CMD_WRITE_PAGE)
			code = `CODE_WRITE_PAGE;
		else
			code = `CODE_READOUT;
		case (hst_q)
			flash_pkg::H_IDLE:
				if (go)
				begin
					hst_d = flash_pkg::H_LOW;
					div_d = 4'h0;
					n_d = 5'h00;
					hsh_d = {tx_q, code};
					oe_d = 1'b1;
					dout_d = code[0];
					rd_d = (sel_d == `CMD_READOUT);
				end
			flash_pkg::H_LOW:
				if (div_q == 4'(`HALF_CYCLES - 1))
				begin
					div_d = 4'h0;
					clk_d = 1'b1;
					hst_d = flash_pkg::H_HIGH;
					if (rd_q && n_q >= 5'(`READ_FIRST) &&
						n_q < 5'(`READ_END))
						rx_d = {dat_s_q[1], rx_q[15:1]};
				end
				else
					div_d = div_q + 4'h1;
			flash_pkg::H_HIGH:
				if (div_q == 4'(`HALF_CYCLES - 1))
				begin
					div_d = 4'h0;
					clk_d = 1'b0;
					n_d = n_q + 5'h01;
					hsh_d = hsh_q >> 1;
					dout_d = hsh_q[1];
					oe_d = (n_q + 5'h01 < drive);
					if (n_q == total - 5'h01)
					begin
						hst_d = flash_pkg::H_IDLE;
						oe_d = 1'b0;
						done_ev = 1'b1;
					end
					else
						hst_d = flash_pkg::H_LOW;
				end
				else
					div_d = div_q + 4'h1;
			default:
				hst_d = flash_pkg::H_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dat_s_q <= 2'h3;
			hst_q <= flash_pkg::H_IDLE;
			div_q <= 4'h0;
			n_q <= 5'h00;
			hsh_q <= 20'h00000;
			clk_q <= 1'b0;
			oe_q <= 1'b0;
			dout_q <= 1'b0;
			rx_q <= 16'h0000;
			rd_q <= 1'b0;
		end
		else
		begin
			dat_s_q <= dat_s_d;
			hst_q <= hst_d;
			div_q <= div_d;
			n_q <= n_d;
			hsh_q <= hsh_d;
			clk_q <= clk_d;
			oe_q <= oe_d;
			dout_q <= dout_d;
			rx_q <= rx_d;
			rd_q <= rd_d;
		end
	end

	// outputs from flops, except hreadyout and hresp which are tied constant
	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq = irq_q;
	assign link.clk_pin = clk_q;
	assign link.host_dout = dout_q;
	assign link.host_oe = oe_q;

endmodule
`default_nettype wire
